// ### core/sdcu_consts.svh
// Constants for the strobe delay control unit: offsets, fields, resets.
// Assumes inclusion by bare name from the design files under core/.
// Functional notes
// - Sixteen-cell group, differential strobe pair reserved
// - Read strobe shifted by DLL quarter code
// - Write strobe clock plus quarter-shifted data clock
// - Write leveling delay from 8-bit code
// - Independent read/write load, step, direction controls
// - Flag when margin setting reaches maximum
// - Three-bit FIFO read and write pointers
// - Data-valid start pulse and burst detect
// - FIFO written by strobe, read by edge clock
`ifndef SDCU_CONSTS_SVH
`define SDCU_CONSTS_SVH

// Group geometry and delay line
`define SDCU_GROUP_PINS    16
`define SDCU_DLY_TAPS      32
`define SDCU_MARGIN_W      4
`define SDCU_MARGIN_DEF    4'h0
`define SDCU_BURST_EDGES   3'h2

// Register byte addresses
`define SDCU_ADDR_CTRL     8'h00
`define SDCU_ADDR_STATUS   8'h04
`define SDCU_ADDR_INT_STAT 8'h08
`define SDCU_ADDR_INT_MASK 8'h0C

// Control fields and reset values
`define SDCU_CTRL_RD_EN    0
`define SDCU_CTRL_WR_EN    1
`define SDCU_CTRL_RESET    2'h3

// Interrupt fields
`define SDCU_INT_BURST     0
`define SDCU_INT_RD_MAX    1
`define SDCU_INT_WR_MAX    2
`define SDCU_INT_MASK_RST  3'h0

`endif

// ### core/sdcu_pkg.sv
// Types shared by the strobe delay control unit.
// Assumes nothing of its surroundings.
package sdcu_pkg;
  // Read window states, one-hot
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_PRE   = 3'b010,
    RD_BURST = 3'b100
  } sdcu_rd_state_type;

  typedef logic [2:0] sdcu_ptr_type;
endpackage

// ### core/sdcu_margin_if.sv
// Margin control bundle between the top and a margin counter.
// Assumes one instance per read or write side.
`timescale 1ns/100ps
interface sdcu_margin_if #(parameter int W = 4);
  logic         load_n;
  logic         step;
  logic         dir;
  logic [W-1:0] value;
  logic         at_max;

  modport ctrl (output load_n, step, dir, input value, at_max);
  modport unit (input load_n, step, dir, output value, at_max);
endinterface

// ### core/sdcu_margin.sv
// Dynamic margin counter for one delay side.
// Assumes controls come from logic on the same clock.
`timescale 1ns/100ps
`include "sdcu_consts.svh"
module sdcu_margin #(
  parameter int W = `SDCU_MARGIN_W
) (
  input wire logic    clk,   // System clock
  input wire logic    rst,   // Synchronous reset
  sdcu_margin_if.unit m      // Margin bundle
);
  localparam logic [W-1:0] MAX = '1;
  localparam logic [W-1:0] DEF = W'(`SDCU_MARGIN_DEF);

  logic         step_q;
  logic         go;
  logic [W-1:0] next_value;

  generate
    if (W < 2 || W > 8) begin : g_bad_width
      $error("margin width out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Step edge, so a held step moves once
  always_ff @(posedge clk) begin
    if (rst) step_q <= 1'b0;
    else     step_q <= m.step;
  end
  assign go = m.step & ~step_q;

  // Next setting, saturating at both ends
  always_comb begin
    next_value = m.value;
    if (!m.load_n)                        next_value = DEF;
    else if (go && m.dir && m.value != MAX) next_value = m.value + 1'b1;
    else if (go && !m.dir && m.value != '0) next_value = m.value - 1'b1;
  end

  // Setting and its maximum flag
  always_ff @(posedge clk) begin
    if (rst) begin
      m.value  <= DEF;
      m.at_max <= 1'b0;
    end else begin
      m.value  <= next_value;
      m.at_max <= (next_value == MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_step_up;
    m.load_n && m.step && !step_q && m.dir && m.value != MAX;
  endsequence

  AST_AT_MAX: assert property (m.at_max == (m.value == MAX))
    else $error("max flag disagrees with setting");
  AST_STEP_UP: assert property (s_step_up |=> m.value == $past(m.value) + 1'b1)
    else $error("step did not add one");
  AST_LOAD: assert property (!m.load_n |=> m.value == DEF)
    else $error("load did not restore default");
endmodule

// ### core/sdcu_top.sv
// Strobe delay control unit: read strobe shift, write clocks,
// write leveling, margin control, FIFO pointers, APB registers.
// Assumes controller signals on SYS_CLK; pins and edge clock are async.
`timescale 1ns/100ps
`include "sdcu_consts.svh"
module sdcu_top #(
  parameter int GROUP_PINS = `SDCU_GROUP_PINS,
  parameter int TAPS       = `SDCU_DLY_TAPS,
  parameter int MW         = `SDCU_MARGIN_W
) (
  input  wire logic        SYS_CLK,             // 25 MHz system clock
  input  wire logic        RESET,               // Synchronous reset
  input  wire logic        PSEL,                // APB select
  input  wire logic        PENABLE,             // APB enable
  input  wire logic        PWRITE,              // APB direction
  input  wire logic [7:0]  PADDR,               // APB byte address
  input  wire logic [31:0] PWDATA,              // APB write data
  output logic      [31:0] PRDATA,              // APB read data
  output logic             PREADY,              // APB ready
  output logic             PSLVERR,             // APB error
  output logic             IRQ,                 // Interrupt level
  input  wire logic        DQS,                 // Memory strobe, true
  input  wire logic        DQS_N,               // Memory strobe, complement
  input  wire logic        EDGE_CLOCK,          // High-speed edge clock
  input  wire logic [7:0]  DLL_QUARTER_CODE,    // Quarter-period taps
  input  wire logic [1:0]  READ_CMD,            // Read indication
  input  wire logic [1:0]  READ_PULSE_SELECT,   // Read pulse position
  input  wire logic        RD_MARGIN_LOAD_N,    // Read margin load
  input  wire logic        RD_MARGIN_STEP,      // Read margin step
  input  wire logic        RD_MARGIN_DIR,       // Read margin up
  input  wire logic        WR_MARGIN_LOAD_N,    // Write margin load
  input  wire logic        WR_MARGIN_STEP,      // Write margin step
  input  wire logic        WR_MARGIN_DIR,       // Write margin up
  input  wire logic        PAUSE,               // Freeze write clocks
  input  wire logic [7:0]  LEVEL_DELAY_CODE,    // Write leveling taps
  output logic             READ_SHIFTED_STROBE, // Shifted read strobe
  output logic             WRITE_STROBE_CLOCK,  // Strobe output clock
  output logic             WRITE_DATA_CLOCK,    // Data output clock
  output logic      [2:0]  FIFO_READ_POINTER,   // Input FIFO read side
  output logic      [2:0]  FIFO_WRITE_POINTER,  // Input FIFO write side
  output logic             READ_VALID_START,    // Valid data start pulse
  output logic             BURST_SEEN,          // Read burst detected
  output logic             RD_MARGIN_AT_MAX,    // Read margin at max
  output logic             WR_MARGIN_AT_MAX     // Write margin at max
);
  localparam int TW = $clog2(TAPS);

  ////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    if (GROUP_PINS != 16) begin : g_bad_group
      $error("strobe group must hold sixteen cells");
    end
    if (TAPS < 4 || TAPS > 256 || (1 << TW) != TAPS) begin : g_bad_taps
      $error("delay taps must be a power of two, 4 to 256");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic                         dqs_p_m;
  logic                         dqs_p_s;
  logic                         dqs_n_m;
  logic                         dqs_n_s;
  logic                         edge_clock_m;
  logic                         edge_clock_s;
  logic                         edge_clock_q;
  logic                         strobe_lvl;
  logic [TAPS-1:0]              rd_line;
  logic [TAPS-1:0]              wr_line;
  logic [TW-1:0]                rd_tap;
  logic [TW-1:0]                w_tap;
  logic [TW-1:0]                d_tap;
  logic                         rs_q;
  logic                         rs_edge;
  logic                         edge_clock_rise;
  sdcu_pkg::sdcu_rd_state_type  rd_state;
  logic [2:0]                   edge_cnt;
  logic [1:0]                   ctrl;
  logic [2:0]                   int_stat;
  logic [2:0]                   int_mask;
  logic [2:0]                   next_int_stat;
  logic [2:0]                   events;
  logic [2:0]                   w1c;
  logic                         burst_q;
  logic                         rd_max_q;
  logic                         wr_max_q;
  logic                         access;
  logic                         wr_go;
  logic                         hit;
  logic [31:0]                  rd_mux;

  sdcu_margin_if #(.W(MW)) rd_m ();
  sdcu_margin_if #(.W(MW)) wr_m ();

  // Saturate a tap sum onto the delay line
  function automatic logic [TW-1:0] sat(input logic [8:0] s);
    if (s > 9'(TAPS - 1)) return TW'(TAPS - 1);
    return s[TW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      dqs_p_m <= 1'b0;
      dqs_p_s <= 1'b0;
      dqs_n_m <= 1'b1;
      dqs_n_s <= 1'b1;
      edge_clock_m  <= 1'b0;
      edge_clock_s  <= 1'b0;
      edge_clock_q  <= 1'b0;
    end else begin
      dqs_p_m <= DQS;
      dqs_p_s <= dqs_p_m;
      dqs_n_m <= DQS_N;
      dqs_n_s <= dqs_n_m;
      edge_clock_m  <= EDGE_CLOCK;
      edge_clock_s  <= edge_clock_m;
      edge_clock_q  <= edge_clock_s;
    end
  end
  assign edge_clock_rise = edge_clock_s & ~edge_clock_q;

  // Differential strobe level, held while the pair agrees
  always_ff @(posedge SYS_CLK) begin
    if (RESET)                  strobe_lvl <= 1'b0;
    else if (dqs_p_s != dqs_n_s) strobe_lvl <= dqs_p_s;
  end

  ////////////////////////////////////////////////////////////////////
  // Margin counters
  assign rd_m.load_n = RD_MARGIN_LOAD_N;
  assign rd_m.step   = RD_MARGIN_STEP;
  assign rd_m.dir    = RD_MARGIN_DIR;
  assign wr_m.load_n = WR_MARGIN_LOAD_N;
  assign wr_m.step   = WR_MARGIN_STEP;
  assign wr_m.dir    = WR_MARGIN_DIR;

  sdcu_margin #(.W(MW)) u_rd_margin (
    .clk (SYS_CLK),
    .rst (RESET),
    .m   (rd_m.unit)
  );

  sdcu_margin #(.W(MW)) u_wr_margin (
    .clk (SYS_CLK),
    .rst (RESET),
    .m   (wr_m.unit)
  );

  assign RD_MARGIN_AT_MAX = rd_m.at_max;
  assign WR_MARGIN_AT_MAX = wr_m.at_max;

  ////////////////////////////////////////////////////////////////////
  // Delay lines and tap selection
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rd_line <= '0;
      wr_line <= '0;
    end else begin
      rd_line <= {rd_line[TAPS-2:0], strobe_lvl};
      wr_line <= {wr_line[TAPS-2:0], edge_clock_s};
    end
  end

  assign rd_tap = sat({1'b0, DLL_QUARTER_CODE} + 9'(rd_m.value));
  assign w_tap  = sat({1'b0, LEVEL_DELAY_CODE} + 9'(wr_m.value));
  assign d_tap  = sat(9'(w_tap) + {1'b0, DLL_QUARTER_CODE});

  // Shifted read strobe for data capture
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      READ_SHIFTED_STROBE <= 1'b0;
      rs_q                <= 1'b0;
    end else begin
      READ_SHIFTED_STROBE <= ctrl[`SDCU_CTRL_RD_EN] & rd_line[rd_tap];
      rs_q                <= READ_SHIFTED_STROBE;
    end
  end
  assign rs_edge = READ_SHIFTED_STROBE ^ rs_q;

  // Write clocks, frozen while paused
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      WRITE_STROBE_CLOCK <= 1'b0;
      WRITE_DATA_CLOCK   <= 1'b0;
    end else if (!PAUSE) begin
      WRITE_STROBE_CLOCK <= ctrl[`SDCU_CTRL_WR_EN] & wr_line[w_tap];
      WRITE_DATA_CLOCK   <= ctrl[`SDCU_CTRL_WR_EN] & wr_line[d_tap];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // FIFO pointers: write on strobe edges, read on edge clock
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      FIFO_WRITE_POINTER <= 3'h0;
    end else if (rs_edge) begin
      FIFO_WRITE_POINTER <= FIFO_WRITE_POINTER + 3'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      FIFO_READ_POINTER <= 3'h0;
    end else if (edge_clock_rise && FIFO_READ_POINTER != FIFO_WRITE_POINTER) begin
      FIFO_READ_POINTER <= FIFO_READ_POINTER + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read window: preamble edges, burst detect, valid start
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rd_state         <= sdcu_pkg::RD_IDLE;
      edge_cnt         <= 3'h0;
      BURST_SEEN       <= 1'b0;
      READ_VALID_START <= 1'b0;
    end else begin
      READ_VALID_START <= 1'b0;
      case (rd_state)
        sdcu_pkg::RD_IDLE: begin
          edge_cnt <= 3'h0;
          if (READ_CMD != 2'h0 && ctrl[`SDCU_CTRL_RD_EN]) begin
            rd_state <= sdcu_pkg::RD_PRE;
          end
        end
        sdcu_pkg::RD_PRE: begin
          if (READ_CMD == 2'h0) begin
            rd_state <= sdcu_pkg::RD_IDLE;
          end else if (rs_edge) begin
            if (edge_cnt == `SDCU_BURST_EDGES - 3'h1) begin
              rd_state   <= sdcu_pkg::RD_BURST;
              BURST_SEEN <= 1'b1;
              edge_cnt   <= 3'h0;
            end else begin
              edge_cnt <= edge_cnt + 3'h1;
            end
          end
        end
        sdcu_pkg::RD_BURST: begin
          if (READ_CMD == 2'h0) begin
            rd_state   <= sdcu_pkg::RD_IDLE;
            BURST_SEEN <= 1'b0;
          end else if (rs_edge && edge_cnt <= {1'b0, READ_PULSE_SELECT}) begin
            READ_VALID_START <= (edge_cnt == {1'b0, READ_PULSE_SELECT});
            edge_cnt         <= edge_cnt + 3'h1;
          end
        end
        default: begin
          rd_state <= sdcu_pkg::RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt events on rising status
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      burst_q  <= 1'b0;
      rd_max_q <= 1'b0;
      wr_max_q <= 1'b0;
    end else begin
      burst_q  <= BURST_SEEN;
      rd_max_q <= rd_m.at_max;
      wr_max_q <= wr_m.at_max;
    end
  end
  assign events = {wr_m.at_max & ~wr_max_q, rd_m.at_max & ~rd_max_q,
                   BURST_SEEN & ~burst_q};

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer
  assign access = PSEL & PENABLE;
  assign wr_go  = access & PREADY & PWRITE;

  // Address decode
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (PADDR == `SDCU_ADDR_CTRL) begin
      rd_mux = {30'h0000_0000, ctrl};
    end else if (PADDR == `SDCU_ADDR_STATUS) begin
      rd_mux = {12'h000, wr_m.value, rd_m.value, 3'h0, wr_m.at_max,
                rd_m.at_max, BURST_SEEN, FIFO_READ_POINTER, FIFO_WRITE_POINTER};
    end else if (PADDR == `SDCU_ADDR_INT_STAT) begin
      rd_mux = {29'h0000_0000, int_stat};
    end else if (PADDR == `SDCU_ADDR_INT_MASK) begin
      rd_mux = {29'h0000_0000, int_mask};
    end else begin
      hit = 1'b0;
    end
  end

  // Handshake and read data
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & ~hit;
      if (access && !PREADY && !PWRITE) PRDATA <= rd_mux;
    end
  end

  // Control and mask registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl     <= `SDCU_CTRL_RESET;
      int_mask <= `SDCU_INT_MASK_RST;
    end else if (wr_go && PADDR == `SDCU_ADDR_CTRL) begin
      ctrl <= PWDATA[1:0];
    end else if (wr_go && PADDR == `SDCU_ADDR_INT_MASK) begin
      int_mask <= PWDATA[2:0];
    end
  end

  // Sticky status, set wins over write-one clear
  assign w1c = (wr_go && PADDR == `SDCU_ADDR_INT_STAT) ? PWDATA[2:0] : 3'h0;
  assign next_int_stat = (int_stat & ~w1c) | events;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      int_stat <= 3'h0;
      IRQ      <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      IRQ      <= |(next_int_stat & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_pre_edge;
    rd_state == sdcu_pkg::RD_PRE && READ_CMD != 2'h0 && rs_edge;
  endsequence

  AST_APB_WAIT: assert property (access && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not after one wait state");
  AST_PAUSE_HOLD: assert property (PAUSE |=> $stable(WRITE_STROBE_CLOCK)
      && $stable(WRITE_DATA_CLOCK))
    else $error("write clocks moved while paused");
  AST_READ_SHIFT: assert property ((ctrl[0] && rd_tap == '0)[*2]
      |-> READ_SHIFTED_STROBE == $past(strobe_lvl, 2))
    else $error("read strobe not delayed as coded");
  AST_DIFF_HOLD: assert property (dqs_p_s == dqs_n_s |=> $stable(strobe_lvl))
    else $error("strobe moved while pair agreed");
  AST_WPTR_STEP: assert property (rs_edge |=>
      FIFO_WRITE_POINTER == $past(FIFO_WRITE_POINTER) + 3'h1)
    else $error("write pointer missed a strobe edge");
  AST_RPTR_EMPTY: assert property (FIFO_READ_POINTER == FIFO_WRITE_POINTER
      |=> $stable(FIFO_READ_POINTER))
    else $error("read pointer passed write pointer");
  AST_BURST_CAUSE: assert property ($rose(BURST_SEEN) |-> $past(rd_state)
      == sdcu_pkg::RD_PRE && $past(rs_edge))
    else $error("burst flag without preamble edge");
  AST_VALID_PULSE: assert property (READ_VALID_START |-> BURST_SEEN
      ##1 !READ_VALID_START)
    else $error("valid start outside burst or too long");
  AST_BURST_ENTRY: assert property (s_pre_edge ##0 edge_cnt == 3'h1
      |=> BURST_SEEN && rd_state == sdcu_pkg::RD_BURST)
    else $error("burst not flagged after preamble");
  AST_IRQ_SET: assert property (|(int_stat & ~$past(int_stat) & $past(int_mask)) |-> IRQ)
    else $error("masked-in event did not raise interrupt");
endmodule

// ### verif/sdcu_mem_model.sv
// Memory-side model: answers each read window with a strobe burst.
// Assumes read_cmd comes from the bench on the system clock.
`timescale 1ns/100ps
module sdcu_mem_model (
  input  wire logic [1:0] read_cmd, // Read window from controller
  input  wire logic       slow,     // Longer read latency
  output logic            dqs,      // Strobe, true
  output logic            dqs_n     // Strobe, complement
);
  ////////////////////
  // Pair parked equal while idle, so no strobe level is valid;
  // low preamble, then six edges at memory rate, then release.
  always begin
    dqs = 1'h1;
    dqs_n = 1'h1;
    wait (read_cmd != 2'h0);
    #(slow ? 407 : 107);
    dqs = 1'h0;
    dqs_n = 1'h1;
    #160;
    repeat (6) begin
      dqs = ~dqs;
      dqs_n = ~dqs_n;
      #160;
    end
    dqs = 1'h1;
    dqs_n = 1'h1;
    wait (read_cmd == 2'h0);
  end
endmodule

// ### verif/tb_ddr_strobe_delay_control.sv
// Self-checking bench for the strobe delay control unit.
// Assumes sdcu_top, sdcu_mem_model and sdcu_consts.svh are compiled.
`timescale 1ns/100ps
`include "sdcu_consts.svh"
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin \
  miscompares++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_ddr_strobe_delay_control;
  logic        SYS_CLK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0;
  logic        PWRITE = 1'h0, PAUSE = 1'h0, EDGE_CLOCK = 1'h0, slow = 1'h0;
  logic [7:0]  PADDR = 8'h0, DLL_QUARTER_CODE = 8'h2, LEVEL_DELAY_CODE = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [1:0]  READ_CMD = 2'h0, READ_PULSE_SELECT = 2'h0;
  logic        RD_MARGIN_LOAD_N = 1'h1, RD_MARGIN_STEP = 1'h0, RD_MARGIN_DIR = 1'h0;
  logic        WR_MARGIN_LOAD_N = 1'h1, WR_MARGIN_STEP = 1'h0, WR_MARGIN_DIR = 1'h0;
  logic        PREADY, PSLVERR, IRQ, DQS, DQS_N, READ_SHIFTED_STROBE, READ_VALID_START;
  logic        WRITE_STROBE_CLOCK, WRITE_DATA_CLOCK, BURST_SEEN;
  logic        RD_MARGIN_AT_MAX, WR_MARGIN_AT_MAX, p, h, g;
  logic [2:0]  FIFO_READ_POINTER, FIFO_WRITE_POINTER;
  logic [33:0] exq[$];
  logic [33:0] e;
  logic [7:0]  hist;
  int          miscompares = 0, check_count = 0, cycles = 0, n, k, m, l0, l1;

  sdcu_top u_dut (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .IRQ, .DQS, .DQS_N, .EDGE_CLOCK, .DLL_QUARTER_CODE,
    .READ_CMD, .READ_PULSE_SELECT, .RD_MARGIN_LOAD_N, .RD_MARGIN_STEP,
    .RD_MARGIN_DIR, .WR_MARGIN_LOAD_N, .WR_MARGIN_STEP, .WR_MARGIN_DIR, .PAUSE,
    .LEVEL_DELAY_CODE, .READ_SHIFTED_STROBE, .WRITE_STROBE_CLOCK,
    .WRITE_DATA_CLOCK, .FIFO_READ_POINTER, .FIFO_WRITE_POINTER,
    .READ_VALID_START, .BURST_SEEN, .RD_MARGIN_AT_MAX, .WR_MARGIN_AT_MAX);
  sdcu_mem_model u_mem (.read_cmd(READ_CMD), .slow(slow), .dqs(DQS), .dqs_n(DQS_N));

  ////////////////////
  // System clock, and edge clock at memory rate, unrelated phase
  always #20 SYS_CLK = ~SYS_CLK;
  initial #13 forever #160 EDGE_CLOCK = ~EDGE_CLOCK;

  // Verdict and end of run
  task automatic conclude();
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      conclude();
    end
  end

  // Answer watcher: oldest note against each completed transfer
  always @(posedge SYS_CLK) begin
    if (PSEL && PENABLE && PREADY) begin
      e = exq.pop_front();
      if (e[33]) `CHK("PRDATA", PRDATA, e[31:0])
      `CHK("PSLVERR", PSLVERR, e[32])
    end
  end

  ////////////////////
  // One APB transfer; for reads d is the expected data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic er);
    @(posedge SYS_CLK);
    exq.push_back({~w, er, d});
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    do @(posedge SYS_CLK); while (!PREADY);
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  // One margin step pulse on either side
  task automatic mstep(input logic wr, input logic up);
    @(posedge SYS_CLK);
    if (wr) begin
      WR_MARGIN_DIR <= up;
      WR_MARGIN_STEP <= 1'h1;
    end else begin
      RD_MARGIN_DIR <= up;
      RD_MARGIN_STEP <= 1'h1;
    end
    @(posedge SYS_CLK);
    WR_MARGIN_STEP <= 1'h0;
    RD_MARGIN_STEP <= 1'h0;
  endtask

  // Cycles from an edge clock rise to the next strobe clock rise
  task automatic lag(output int c);
    do @(posedge SYS_CLK); while (EDGE_CLOCK);
    do @(posedge SYS_CLK); while (!EDGE_CLOCK);
    c = 0;
    do begin
      p = WRITE_STROBE_CLOCK;
      @(posedge SYS_CLK);
      c++;
    end while (!(WRITE_STROBE_CLOCK && !p));
  endtask

  ////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h4B09));
    repeat (8) @(posedge SYS_CLK);
    RESET <= 1'h0;
    apb(1'h0, `SDCU_ADDR_CTRL, 32'h3, 1'h0);
    apb(1'h0, `SDCU_ADDR_STATUS, 32'h0, 1'h0);
    apb(1'h0, `SDCU_ADDR_INT_MASK, 32'h0, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 1'h1);
    apb(1'h1, 8'h14, 32'hFFFFFFFF, 1'h1);
    // Read bursts over every pulse select and read code
    for (int s = 0; s < 4; s++) begin
      @(posedge SYS_CLK);
      READ_PULSE_SELECT <= s[1:0];
      slow <= s[0];
      DLL_QUARTER_CODE <= 8'(2 * (s % 2));
      READ_CMD <= 2'(s % 3 + 1);
      for (n = 0; n < 400 && !BURST_SEEN; n++) @(posedge SYS_CLK);
      for (n = 0; n < 400 && !READ_VALID_START; n++) @(posedge SYS_CLK);
      `CHK("valid gap", n, 4 * (s + 1))
      `CHK("burst", BURST_SEEN, 1'h1)
      READ_CMD <= 2'h0;
      repeat (80) @(posedge SYS_CLK);
      `CHK("burst end", BURST_SEEN, 1'h0)
      k = (6 * (s + 1)) % 8;
      apb(1'h0, `SDCU_ADDR_STATUS, 32'(k | k << 3), 1'h0);
      `CHK("ptr pins", {FIFO_READ_POINTER, FIFO_WRITE_POINTER}, 6'(k | k << 3))
    end
    // Interrupt raise, mask and clear
    apb(1'h0, `SDCU_ADDR_INT_STAT, 32'h1, 1'h0);
    apb(1'h1, `SDCU_ADDR_INT_MASK, 32'h7, 1'h0);
    repeat (2) @(posedge SYS_CLK);
    `CHK("irq set", IRQ, 1'h1)
    apb(1'h1, `SDCU_ADDR_INT_STAT, 32'h1, 1'h0);
    repeat (2) @(posedge SYS_CLK);
    `CHK("irq clear", IRQ, 1'h0)
    // Margins: write side random, read side past maximum
    m = $urandom_range(14, 2);
    repeat (m) mstep(1'h1, 1'h1);
    mstep(1'h1, 1'h0);
    repeat (16) mstep(1'h0, 1'h1);
    repeat (2) @(posedge SYS_CLK);
    `CHK("rd max", RD_MARGIN_AT_MAX, 1'h1)
    `CHK("wr max", WR_MARGIN_AT_MAX, 1'h0)
    `CHK("irq max", IRQ, 1'h1)
    apb(1'h0, `SDCU_ADDR_STATUS, 32'h80 | 32'hF000 | 32'((m - 1) << 16), 1'h0);
    apb(1'h0, `SDCU_ADDR_INT_STAT, 32'h2, 1'h0);
    RD_MARGIN_LOAD_N <= 1'h0;
    @(posedge SYS_CLK);
    RD_MARGIN_LOAD_N <= 1'h1;
    apb(1'h1, `SDCU_ADDR_INT_STAT, 32'h2, 1'h0);
    apb(1'h0, `SDCU_ADDR_STATUS, 32'((m - 1) << 16), 1'h0);
    `CHK("irq off", IRQ, 1'h0)
    // Write clocks: leveling delay, quarter shift, pause
    WR_MARGIN_LOAD_N <= 1'h0;
    @(posedge SYS_CLK);
    WR_MARGIN_LOAD_N <= 1'h1;
    repeat (20) @(posedge SYS_CLK);
    lag(l0);
    k = $urandom_range(2, 1);
    LEVEL_DELAY_CODE <= k[7:0];
    repeat (20) @(posedge SYS_CLK);
    lag(l1);
    `CHK("level lag", l1 - l0, k)
    for (n = 0; n < 40; n++) begin
      @(posedge SYS_CLK);
      hist = {hist[6:0], WRITE_STROBE_CLOCK};
      if (n > 8) `CHK("data clk", WRITE_DATA_CLOCK, hist[2])
    end
    PAUSE <= 1'h1;
    repeat (3) @(posedge SYS_CLK);
    h = WRITE_STROBE_CLOCK;
    g = WRITE_DATA_CLOCK;
    repeat (20) begin
      @(posedge SYS_CLK);
      `CHK("pause strobe", WRITE_STROBE_CLOCK, h)
      `CHK("pause data", WRITE_DATA_CLOCK, g)
    end
    PAUSE <= 1'h0;
    k = 0;
    repeat (24) begin
      p = WRITE_STROBE_CLOCK;
      @(posedge SYS_CLK);
      if (WRITE_STROBE_CLOCK !== p) k++;
    end
    `CHK("clock runs", k > 3, 1'h1)
    // Write clocks disabled through the control register
    apb(1'h1, `SDCU_ADDR_CTRL, 32'h1, 1'h0);
    apb(1'h0, `SDCU_ADDR_CTRL, 32'h1, 1'h0);
    `CHK("wr clk off", {WRITE_STROBE_CLOCK, WRITE_DATA_CLOCK}, 2'h0)
    conclude();
  end
endmodule
